// *** rtl/shl_defines.vh ***
// constants for the serial host loader
`ifndef SHL_DEFINES_VH
`define SHL_DEFINES_VH
`define SHL_CMD_GROUP_W     4
`define SHL_CMD_RST_GRP     4'h1
`define SHL_CMD_LOOP        8'h20
`define SHL_CMD_MWR         8'h30
`define SHL_CMD_MRD         8'h40
`define SHL_CMD_USR         8'h50
`define SHL_ADDR_W          18
`define SHL_LEN_W           16
`define SHL_NCORE           4
`define SHL_CORE_BASE_1     19'h20000
`define SHL_CORE_BASE_2     19'h40000
`define SHL_CORE_BASE_3     19'h60000
`define SHL_PMEM_OFS        18'h00000
`define SHL_DMEM_OFS        18'h10000
`define SHL_CORE_BIT_HI     17
`define SHL_CORE_BIT_LO     17
`define SHL_DMEM_BIT        16
`define SHL_LOCAL_W         16
`define SHL_RST_VAL         4'hF
`endif

// *** rtl/shl_addr_map.v ***
// splits a link address into core, memory select and local byte address
`timescale 1ns/1ps
`include "shl_defines.vh"
module shl_addr_map (
  input  wire [17:0] addr_i,
  output wire [1:0]  core_o,
  output wire        dmem_o,
  output wire [15:0] local_o
);
  // core bases are 128K apart, data memory sits 64K above each base
  // limitation: an 18-bit link address only reaches cores 0 and 1
  assign core_o  = {1'b0, addr_i[`SHL_CORE_BIT_HI]};
  assign dmem_o  = addr_i[`SHL_DMEM_BIT];
  assign local_o = addr_i[`SHL_LOCAL_W-1:0];
endmodule // shl_addr_map

// *** rtl/shl_loader.v ***
// serial host command interpreter: reset, loopback, memory load/read, user stream
`timescale 1ns/1ps
`include "shl_defines.vh"
module shl_loader (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  output wire        tx_valid_o,
  output wire [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  output wire [3:0]  core_rst_o,
  output wire        mem_we_o,
  output wire        mem_re_o,
  output wire [1:0]  mem_core_o,
  output wire        mem_dmem_o,
  output wire [15:0] mem_addr_o,
  output wire [7:0]  mem_wdata_o,
  input  wire        mem_rvalid_i,
  input  wire [7:0]  mem_rdata_i,
  input  wire        core0_rd_i,
  output wire        core0_stall_o,
  output wire [7:0]  received_byte_register_o,
  output wire        received_byte_valid_o,
  input  wire        core0_tx_valid_i,
  input  wire [7:0]  core0_tx_data_i,
  output wire        core0_tx_ready_o
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_LOOP = 4'h1;
  localparam [3:0] S_A2   = 4'h2;
  localparam [3:0] S_A1   = 4'h3;
  localparam [3:0] S_A0   = 4'h4;
  localparam [3:0] S_LH   = 4'h5;
  localparam [3:0] S_LL   = 4'h6;
  localparam [3:0] S_WDAT = 4'h7;
  localparam [3:0] S_RREQ = 4'h8;
  localparam [3:0] S_RWT  = 4'h9;
  localparam [3:0] S_UH   = 4'hA;
  localparam [3:0] S_UL   = 4'hB;
  localparam [3:0] S_UDAT = 4'hC;

  reg [3:0]  st_q, st_d;
  reg        is_rd_q, is_rd_d;
  reg [17:0] addr_q, addr_d;
  reg [15:0] len_q, len_d;
  reg [3:0]  rst_q, rst_d;
  reg        txv_q, txv_d;
  reg [7:0]  txb_q, txb_d;
  reg        we_q, we_d;
  reg        re_q, re_d;
  reg [7:0]  wd_q, wd_d;
  reg [17:0] maddr_q, maddr_d;
  reg [7:0]  rxb_q, rxb_d;
  reg        rxv_q, rxv_d;
  reg        own_q, own_d;

  wire [1:0]  core_w;
  wire        dmem_w;
  wire [15:0] local_w;

  // a byte must not be taken while the echo/loopback slot is still full
  wire tx_busy = txv_q & ~(tx_ready_i & ~own_q);

  function is_last;
    input [15:0] len;
    begin
      is_last = (len == 16'h0001);
    end
  endfunction

  shl_addr_map u_map (
    .addr_i  (maddr_q),
    .core_o  (core_w),
    .dmem_o  (dmem_w),
    .local_o (local_w)
  );

  always @* begin
    st_d    = st_q;
    is_rd_d = is_rd_q;
    addr_d  = addr_q;
    len_d   = len_q;
    rst_d   = rst_q;
    txv_d   = txv_q;
    txb_d   = txb_q;
    we_d    = 1'b0;
    re_d    = 1'b0;
    wd_d    = wd_q;
    maddr_d = maddr_q;
    rxb_d   = rxb_q;
    rxv_d   = rxv_q;
    own_d   = own_q;
    if (txv_q && tx_ready_i && !own_q)
      txv_d = 1'b0;
    if (core0_rd_i && rxv_q)
      rxv_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (rx_valid_i) begin
          if (rx_data_i[7:4] == `SHL_CMD_RST_GRP)
            rst_d = rx_data_i[3:0];
          else if (rx_data_i == `SHL_CMD_LOOP)
            st_d = S_LOOP;
          else if (rx_data_i == `SHL_CMD_MWR) begin
            st_d = S_A2;
            is_rd_d = 1'b0;
          end else if (rx_data_i == `SHL_CMD_MRD) begin
            st_d = S_A2;
            is_rd_d = 1'b1;
          end else if (rx_data_i == `SHL_CMD_USR)
            st_d = S_UH;
          // other codes fall through and are dropped
        end
      end
      S_LOOP: begin
        if (rx_valid_i && !tx_busy) begin
          txv_d = 1'b1;
          txb_d = rx_data_i;
          st_d  = S_IDLE;
        end
      end
      S_A2: if (rx_valid_i) begin
        addr_d[17:16] = rx_data_i[1:0];
        st_d = S_A1;
      end
      S_A1: if (rx_valid_i) begin
        addr_d[15:8] = rx_data_i;
        st_d = S_A0;
      end
      S_A0: if (rx_valid_i) begin
        addr_d[7:0] = rx_data_i;
        st_d = S_LH;
      end
      S_LH: if (rx_valid_i) begin
        len_d[15:8] = rx_data_i;
        st_d = S_LL;
      end
      S_LL: if (rx_valid_i) begin
        len_d[7:0] = rx_data_i;
        maddr_d = addr_q;
        if ({len_q[15:8], rx_data_i} == 16'h0000)
          st_d = S_IDLE;
        else if (is_rd_q)
          st_d = S_RREQ;
        else
          st_d = S_WDAT;
      end
      S_WDAT: begin
        if (rx_valid_i && !tx_busy) begin
          we_d  = 1'b1;
          wd_d  = rx_data_i;
          txv_d = 1'b1;
          txb_d = rx_data_i;
        end
        if (we_q) begin
          maddr_d = maddr_q + 18'h00001;
          len_d   = len_q - 16'h0001;
          if (is_last(len_q))
            st_d = S_IDLE;
        end
      end
      S_RREQ: begin
        if (!tx_busy) begin
          re_d = dmem_w;
          if (!dmem_w) begin
            // program memory is not readable: reply zero to keep byte count
            txv_d   = 1'b1;
            txb_d   = 8'h00;
            maddr_d = maddr_q + 18'h00001;
            len_d   = len_q - 16'h0001;
            st_d    = is_last(len_q) ? S_IDLE : S_RREQ;
          end else
            st_d = S_RWT;
        end
      end
      S_RWT: begin
        if (mem_rvalid_i && re_q == 1'b0 && !txv_q) begin
          txv_d = 1'b1;
          txb_d = mem_rdata_i;
        end
        if (txv_d && !txv_q) begin
          maddr_d = maddr_q + 18'h00001;
          len_d   = len_q - 16'h0001;
          st_d    = is_last(len_q) ? S_IDLE : S_RREQ;
        end
      end
      S_UH: if (rx_valid_i) begin
        len_d[15:8] = rx_data_i;
        st_d = S_UL;
      end
      S_UL: if (rx_valid_i) begin
        len_d[7:0] = rx_data_i;
        st_d = ({len_q[15:8], rx_data_i} == 16'h0000) ? S_IDLE : S_UDAT;
      end
      S_UDAT: if (rx_valid_i) begin
        rxb_d = rx_data_i;
        rxv_d = 1'b1;
        len_d = len_q - 16'h0001;
        if (is_last(len_q))
          st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    // core 0 may use the transmit line only while the interpreter is idle
    if (!txv_d && core0_tx_valid_i && st_d == S_IDLE && st_q == S_IDLE) begin
      txv_d = 1'b1;
      txb_d = core0_tx_data_i;
      own_d = 1'b1;
    end
    if (own_q && tx_ready_i) begin
      own_d = 1'b0;
      txv_d = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q    <= S_IDLE;
      is_rd_q <= 1'b0;
      addr_q  <= 18'h00000;
      len_q   <= 16'h0000;
      rst_q   <= `SHL_RST_VAL;
      txv_q   <= 1'b0;
      txb_q   <= 8'h00;
      we_q    <= 1'b0;
      re_q    <= 1'b0;
      wd_q    <= 8'h00;
      maddr_q <= 18'h00000;
      rxb_q   <= 8'h00;
      rxv_q   <= 1'b0;
      own_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      is_rd_q <= is_rd_d;
      addr_q  <= addr_d;
      len_q   <= len_d;
      rst_q   <= rst_d;
      txv_q   <= txv_d;
      txb_q   <= txb_d;
      we_q    <= we_d;
      re_q    <= re_d;
      wd_q    <= wd_d;
      maddr_q <= maddr_d;
      rxb_q   <= rxb_d;
      rxv_q   <= rxv_d;
      own_q   <= own_d;
    end
  end

  assign tx_valid_o               = txv_q;
  assign tx_data_o                = txb_q;
  assign core_rst_o               = rst_q;
  assign mem_we_o                 = we_q;
  assign mem_re_o                 = re_q;
  assign mem_core_o               = core_w;
  assign mem_dmem_o               = dmem_w;
  assign mem_addr_o               = local_w;
  assign mem_wdata_o              = wd_q;
  assign received_byte_register_o = rxb_q;
  assign received_byte_valid_o    = rxv_q;
  assign core0_stall_o            = core0_rd_i & ~rxv_q;
  assign core0_tx_ready_o         = own_q & tx_ready_i;
endmodule // shl_loader

// *** test/shl_loader_chk.sv ***
// port assertions for the serial host loader
`timescale 1ns/1ps
module shl_loader_chk (
  input logic       clk_i,
  input logic       rstn_i,
  input logic       rx_valid_i,
  input logic [7:0] rx_data_i,
  input logic       tx_valid_o,
  input logic [7:0] tx_data_o,
  input logic       tx_ready_i,
  input logic [3:0] core_rst_o,
  input logic       mem_we_o,
  input logic       mem_re_o,
  input logic       mem_dmem_o,
  input logic [7:0] mem_wdata_o,
  input logic       mem_rvalid_i,
  input logic [7:0] mem_rdata_i,
  input logic       core0_rd_i,
  input logic       core0_stall_o,
  input logic       received_byte_valid_o,
  input logic       core0_tx_valid_i,
  input logic [7:0] core0_tx_data_i,
  input logic       core0_tx_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("tx byte not held");
  chk_write_echo: assert property (mem_we_o |->
    tx_valid_o && tx_data_o == mem_wdata_o) else $error("write not echoed");
  chk_we_pulse: assert property (mem_we_o |=> !mem_we_o)
    else $error("write strobe too long");
  chk_read_dmem: assert property (mem_re_o |-> mem_dmem_o && !mem_we_o)
    else $error("program memory read");
  chk_read_send: assert property (mem_rvalid_i |=>
    tx_valid_o && tx_data_o == $past(mem_rdata_i)) else $error("read byte not sent");
  chk_stall_rule: assert property (core0_stall_o ==
    (core0_rd_i && !received_byte_valid_o)) else $error("stall wrong");
  chk_core_send: assert property (core0_tx_ready_o |->
    tx_valid_o && tx_data_o == core0_tx_data_i) else $error("core byte lost");
  chk_reset_flags: assert property (!$stable(core_rst_o) |-> $past(rx_valid_i) &&
    $past(rx_data_i[7:4]) == 4'h1 && core_rst_o == $past(rx_data_i[3:0]))
    else $error("reset flags changed wrongly");
endmodule // shl_loader_chk
bind shl_loader shl_loader_chk chk_u (.clk_i, .rstn_i, .rx_valid_i, .rx_data_i, .tx_valid_o,
  .tx_data_o, .tx_ready_i, .core_rst_o, .mem_we_o, .mem_re_o, .mem_dmem_o, .mem_wdata_o,
  .mem_rvalid_i, .mem_rdata_i, .core0_rd_i, .core0_stall_o, .received_byte_valid_o,
  .core0_tx_valid_i, .core0_tx_data_i, .core0_tx_ready_o);

// *** test/shl_mem_model.sv ***
// core memory model answering the loader's strobes
`timescale 1ns/1ps
module shl_mem_model #(parameter int DLY = 3) (
  input  logic        clk_i,
  input  logic        we_i,
  input  logic        re_i,
  input  logic [1:0]  core_i,
  input  logic [15:0] addr_i,
  input  logic [7:0]  wdata_i,
  output logic        rvalid_o,
  output logic [7:0]  rdata_o
);
  logic [7:0] m [0:1023];
  logic [9:0] ra;
  int         cnt;
  initial begin
    rvalid_o = 1'b0;
    rdata_o = 8'h00;
    cnt = 0;
    ra = 10'h000;
    foreach (m[i]) m[i] = 8'h00;
  end
  // idle data toggles so a stale byte never looks valid
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (we_i) m[{core_i, addr_i[7:0]}] <= wdata_i;
    if (re_i) begin
      ra <= {core_i, addr_i[7:0]};
      cnt <= DLY;
    end else if (cnt == 1) begin
      rvalid_o <= 1'b1;
      rdata_o <= m[ra];
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule // shl_mem_model

// *** test/shl_loader_bench.sv ***
// self-checking bench for the serial host loader
`timescale 1ns/1ps
module shl_loader_bench;
  logic clk_i = 0, rstn_i = 0, rx_valid_i = 0, tx_ready_i = 0, core0_rd_i = 0;
  logic core0_tx_valid_i = 0, tx_valid_o, mem_we_o, mem_re_o, mem_dmem_o, mem_rvalid_i;
  logic stall, rbv, ctr;
  logic [7:0] rx_data_i = 8'h00, core0_tx_data_i = 8'h00, tx_data_o, mem_wdata_o;
  logic [7:0] mem_rdata_i, rbr, tq[$];
  logic [3:0] core_rst_o;
  logic [1:0] mem_core_o;
  logic [15:0] mem_addr_o;
  logic [18:0] wq[$];
  int errors = 0, checks_done = 0, cyc = 0, nre = 0;
  shl_loader dut_u (.clk_i, .rstn_i, .rx_valid_i, .rx_data_i, .tx_valid_o, .tx_data_o,
    .tx_ready_i, .core_rst_o, .mem_we_o, .mem_re_o, .mem_core_o, .mem_dmem_o, .mem_addr_o,
    .mem_wdata_o, .mem_rvalid_i, .mem_rdata_i, .core0_rd_i, .core0_stall_o(stall),
    .received_byte_register_o(rbr), .received_byte_valid_o(rbv), .core0_tx_valid_i,
    .core0_tx_data_i, .core0_tx_ready_o(ctr));
  shl_mem_model #(.DLY(3)) mem_u (.clk_i, .we_i(mem_we_o), .re_i(mem_re_o),
    .core_i(mem_core_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  initial forever #10 clk_i = ~clk_i;
  // transmitter ready every other cycle keeps the slot busy
  always @(posedge clk_i) begin
    cyc++;
    tx_ready_i <= ~tx_ready_i;
    if (tx_valid_o && tx_ready_i) tq.push_back(tx_data_o);
    if (mem_we_o) wq.push_back({mem_core_o, mem_dmem_o, mem_addr_o});
    if (mem_re_o) nre++;
    if (core0_tx_valid_i && ctr) core0_tx_valid_i <= 1'b0;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // gap lets the echo drain before the next byte
  task automatic tx(input logic [7:0] b);
    rx_valid_i <= 1'b1;
    rx_data_i <= b;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_data_i <= ~b;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic hdr(input logic [7:0] c, input logic [17:0] a, input logic [15:0] n);
    tx(c); tx({6'h00, a[17:16]}); tx(a[15:8]); tx(a[7:0]); tx(n[15:8]); tx(n[7:0]);
  endtask
  task automatic pop(input logic [7:0] e);
    if (tq.size() == 0) chk(32'h100, {24'h0, e});
    else chk({24'h0, tq.pop_front()}, {24'h0, e});
  endtask
  task automatic t_rst;
    chk(core_rst_o, 4'hF);
    tx(8'h15); chk(core_rst_o, 4'h5);
    tx(8'h1A); chk(core_rst_o, 4'hA);
    tx(8'h10); chk(core_rst_o, 4'h0);
    $display("reset flags done");
  endtask
  task automatic t_loop;
    tq.delete();
    tx(8'h77); chk(tq.size(), 0);
    tx(8'h20); tx(8'hA5); pop(8'hA5);
    $display("loopback done");
  endtask
  task automatic t_wr;
    tq.delete(); wq.delete();
    hdr(8'h30, 18'h100FE, 16'h0003);
    tx(8'h11); tx(8'h22); tx(8'h33);
    hdr(8'h30, 18'h20005, 16'h0001); tx(8'h44);
    chk(wq.size(), 4);
    chk(wq[0], 19'h100FE); chk(wq[1], 19'h100FF); chk(wq[2], 19'h10100);
    chk(wq[3], 19'h20005);
    pop(8'h11); pop(8'h22); pop(8'h33); pop(8'h44);
    $display("memory write done");
  endtask
  task automatic t_rd;
    tq.delete(); nre = 0;
    hdr(8'h40, 18'h100FE, 16'h0003); repeat (40) @(posedge clk_i);
    chk(nre, 3);
    pop(8'h11); pop(8'h22); pop(8'h33);
    hdr(8'h40, 18'h00000, 16'h0002); repeat (30) @(posedge clk_i);
    chk(nre, 3);
    pop(8'h00); pop(8'h00); chk(tq.size(), 0);
    $display("memory read done");
  endtask
  task automatic t_usr;
    tx(8'h50); tx(8'h00); tx(8'h02); tx(8'hC3);
    chk(rbv, 1); chk(rbr, 8'hC3);
    core0_rd_i <= 1'b1; @(posedge clk_i); core0_rd_i <= 1'b0; @(posedge clk_i);
    chk(rbv, 0);
    core0_rd_i <= 1'b1; @(posedge clk_i); #1 chk(stall, 1);
    @(posedge clk_i); core0_rd_i <= 1'b0;
    tx(8'h3C); chk(rbr, 8'h3C);
    tx(8'h50); tx(8'h00); tx(8'h00);
    tq.delete(); tx(8'h20); tx(8'h5A); pop(8'h5A);
    $display("user stream done");
  endtask
  task automatic t_ctx;
    tq.delete();
    core0_tx_valid_i <= 1'b1; core0_tx_data_i <= 8'h6E;
    repeat (12) @(posedge clk_i);
    chk(core0_tx_valid_i, 0); pop(8'h6E);
    $display("core send done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_rst(); t_loop(); t_wr(); t_rd(); t_usr(); t_ctx();
    final_report();
  end
endmodule // shl_loader_bench
